// ### logic/smd_pkg.sv
// Purpose: shared constants and types of the serial clock divider master
// Assumes: apb with 32-bit data, byte addresses, one word per register
// Notes: every offset, field position, timing reset value and timing figure lives here
`default_nettype none

package smd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] FRAME_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] RXDATA_OFS = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_CPOL_POS = 0;
  localparam int CTRL_CPHA_POS = 1;
  localparam int CTRL_LSB_POS = 2;
  localparam int CTRL_SEL_POS = 3;
  localparam int CTRL_CSPOL_POS = 4;
  localparam int TIM_DIVISOR_POS = 0;
  localparam int TIM_PRESCALE_POS = 8;
  localparam int TIM_MODE_POS = 12;
  localparam int FRM_DATA_POS = 0;
  localparam int FRM_ADDR_POS = 8;
  localparam int FRM_READ_POS = 16;
  localparam int STA_BUSY_POS = 0;
  localparam int STA_RXVALID_POS = 1;
  localparam int STA_EMPTY_POS = 2;
  localparam int STA_FULL_POS = 3;
  localparam int STA_COUNT_POS = 8;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int WORD_BITS = 8;
  localparam int FRAME_BITS = 2 * WORD_BITS;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] DIVISOR_RST = 8'h01;
  localparam logic [1:0] PRESCALE_RST = 2'h0;
  localparam logic DIVMODE_RST = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int REF_CLK_KHZ = 32000;
  localparam int SYS_CLK_KHZ = 50000;
  localparam logic [6:0] REF_STEP = 7'(REF_CLK_KHZ / 1000);
  localparam logic [6:0] SYS_STEP = 7'(SYS_CLK_KHZ / 1000);

  typedef struct packed {
    logic [1:0] csPol;
    logic csSel;
    logic lsbFirst;
    logic cpha;
    logic cpol;
  } smd_ctrl_type;

  typedef struct packed {
    logic divMode;
    logic [1:0] prescaleExponent;
    logic [7:0] divisorCount;
  } smd_timing_type;

  typedef struct packed {
    logic isRead;
    logic [7:0] addrWord;
    logic [7:0] dataWord;
  } smd_frame_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_END = 2'b11
  } smd_state_type;

endpackage : smd_pkg

`default_nettype wire

// ### logic/smd_fifo.sv
// Purpose: synchronous fifo with valid and ready on both sides
// Assumes: one clock, synchronous active-low reset, clock enable freezes it
// Notes: depth must be a power of two
`default_nettype none

module smd_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic push;
  logic pop;

  assign count = wrPtr_ff - rdPtr_ff;
  assign inReady = (count != (AW + 1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr_ff[AW-1:0]];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end

endmodule : smd_fifo

`default_nettype wire

// ### logic/smd_spi_master.sv
// Purpose: apb-programmed serial master with programmable serial clock divider
// Assumes: clk at 50 MHz; a 32 MHz reference rate is made by a fractional tick
// Notes: frames are one address word then one data word, queued in a fifo
//
// How it works
// - two chip select outputs, each with its own software-set active level
// - master drives serial clock; polarity and phase give four modes
// - serial clock programmable from 32 MHz / 4082 (about 7.84 kHz) up to 16 MHz
// - each word shifts msb first or lsb first, software selects
// - every frame opens with an 8-bit address and read/write word
// - software must code the read/write flag and address into the fixed 8-bit address word
// - single read: send address word, then capture one returned data byte
// - single write: send address word, then one data byte
// - rate set by 1-bit mode, 2-bit prescale exponent, 8-bit divisor count
// - mode 1: serial clock = reference / (2^prescale * divisor * 2)
// - mode 0 with prescale 2 or 3 adds two reference cycles to period
// - after reset mode 0, prescale 00, divisor 1: half the reference
// - divider runs from a 32 MHz reference, so fastest clock is 16 MHz
`default_nettype none

module smd_spi_master (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  output logic [1:0] chipSel
);

  // ****************************************
  // declarations
  // ****************************************
  smd_pkg::smd_ctrl_type ctrl_ff;
  smd_pkg::smd_timing_type timing_ff;
  smd_pkg::smd_frame_type frame_ff;
  smd_pkg::smd_frame_type fifoOut;
  smd_pkg::smd_state_type state_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic sclk_ff;
  logic mosi_ff;
  logic [1:0] chipSel_ff;
  logic [2:0] misoSync_ff;
  logic misoFilt_ff;
  logic [6:0] refAcc_ff;
  logic refTick;
  logic [10:0] halfCnt_ff;
  logic [10:0] halfLen;
  logic halfTick;
  logic [4:0] edgeCnt_ff;
  logic [7:0] rxShift_ff;
  logic [7:0] rxData_ff;
  logic rxValid_ff;
  logic fifoInReady;
  logic fifoOutValid;
  logic [$clog2(smd_pkg::FIFO_DEPTH):0] fifoCount;
  logic access;
  logic done;
  logic frameWr;
  logic rxRead;
  logic leading;
  logic sampleEdge;
  logic lastEdge;
  logic [31:0] rdMux;
  logic mapped;

  // ****************************************
  // helpers
  // ****************************************
  // bit of the 16-bit frame sent at position idx, address word first
  function automatic logic frameBit(input smd_pkg::smd_frame_type f, input logic [3:0] idx,
                                    input logic lsb);
    logic [7:0] word;
    logic [2:0] pos;
    word = idx[3] ? f.dataWord : f.addrWord;
    pos = lsb ? idx[2:0] : 3'(7 - idx[2:0]);
    return word[pos];
  endfunction : frameBit

  // chip select pattern: only the selected line asserted, each at its own level
  function automatic logic [1:0] csLevels(input smd_pkg::smd_ctrl_type c, input logic act);
    logic [1:0] lv;
    lv = ~c.csPol;
    if (act) begin
      lv[c.csSel] = c.csPol[c.csSel];
    end
    return lv;
  endfunction : csLevels

  // ****************************************
  // apb slave
  // ****************************************
  assign access = psel & penable;
  assign done = access & pready_ff;
  assign mapped = (paddr == smd_pkg::CTRL_OFS) || (paddr == smd_pkg::TIMING_OFS) ||
                  (paddr == smd_pkg::FRAME_OFS) || (paddr == smd_pkg::STATUS_OFS) ||
                  (paddr == smd_pkg::RXDATA_OFS);
  assign frameWr = done & pwrite & (paddr == smd_pkg::FRAME_OFS) & ~pslverr_ff;
  assign rxRead = done & ~pwrite & (paddr == smd_pkg::RXDATA_OFS);

  always_comb begin
    rdMux = '0;
    unique case (paddr)
      smd_pkg::CTRL_OFS: rdMux[5:0] = ctrl_ff;
      smd_pkg::TIMING_OFS: begin
        rdMux[smd_pkg::TIM_DIVISOR_POS +: 8] = timing_ff.divisorCount;
        rdMux[smd_pkg::TIM_PRESCALE_POS +: 2] = timing_ff.prescaleExponent;
        rdMux[smd_pkg::TIM_MODE_POS] = timing_ff.divMode;
      end
      smd_pkg::STATUS_OFS: begin
        rdMux[smd_pkg::STA_BUSY_POS] = (state_ff != smd_pkg::ST_IDLE);
        rdMux[smd_pkg::STA_RXVALID_POS] = rxValid_ff;
        rdMux[smd_pkg::STA_EMPTY_POS] = ~fifoOutValid;
        rdMux[smd_pkg::STA_FULL_POS] = ~fifoInReady;
        rdMux[smd_pkg::STA_COUNT_POS +: 5] = fifoCount;
      end
      smd_pkg::RXDATA_OFS: rdMux[7:0] = rxData_ff;
      default: rdMux = '0;
    endcase
  end

  // a frame write waits in the access phase while the fifo is full
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else if (ce) begin
      if (access && !pready_ff) begin
        if (!(pwrite && paddr == smd_pkg::FRAME_OFS && !fifoInReady)) begin
          pready_ff <= 1'b1;
          pslverr_ff <= ~mapped;
          prdata_ff <= rdMux;
        end
      end else begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_ff <= '0;
    end else if (ce && done && pwrite && paddr == smd_pkg::CTRL_OFS) begin
      ctrl_ff <= pwdata[5:0];
    end
  end

  // software keeps divisor count nonzero; a zero is stored as written
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timing_ff.divMode <= smd_pkg::DIVMODE_RST;
      timing_ff.prescaleExponent <= smd_pkg::PRESCALE_RST;
      timing_ff.divisorCount <= smd_pkg::DIVISOR_RST;
    end else if (ce && done && pwrite && paddr == smd_pkg::TIMING_OFS) begin
      timing_ff.divMode <= pwdata[smd_pkg::TIM_MODE_POS];
      timing_ff.prescaleExponent <= pwdata[smd_pkg::TIM_PRESCALE_POS +: 2];
      timing_ff.divisorCount <= pwdata[smd_pkg::TIM_DIVISOR_POS +: 8];
    end
  end

  // ****************************************
  // frame queue
  // ****************************************
  smd_fifo #(
    .WIDTH($bits(smd_pkg::smd_frame_type)),
    .DEPTH(smd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .inValid(frameWr),
    .inReady(fifoInReady),
    .inData(pwdata[smd_pkg::FRM_READ_POS:0]),
    .outValid(fifoOutValid),
    .outReady(state_ff == smd_pkg::ST_IDLE),
    .outData(fifoOut),
    .count(fifoCount)
  );

  // ****************************************
  // clock divider
  // ****************************************
  // 32/50 fractional tick: average reference rate, edge jitter up to one clk
  assign refTick = (refAcc_ff + smd_pkg::REF_STEP) >= smd_pkg::SYS_STEP;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refAcc_ff <= '0;
    end else if (ce) begin
      refAcc_ff <= refTick ? 7'(refAcc_ff + smd_pkg::REF_STEP - smd_pkg::SYS_STEP)
                           : 7'(refAcc_ff + smd_pkg::REF_STEP);
    end
  end

  // half period in reference cycles: 2^prescale * divisor, plus one in mode 0 with prescale 2 or 3
  always_comb begin
    halfLen = 11'(timing_ff.divisorCount) << timing_ff.prescaleExponent;
    if (!timing_ff.divMode && timing_ff.prescaleExponent[1]) begin
      halfLen = 11'(halfLen + 11'h001);
    end
  end

  assign halfTick = refTick && (halfCnt_ff + 11'h001 >= halfLen);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halfCnt_ff <= '0;
    end else if (ce) begin
      if (state_ff == smd_pkg::ST_IDLE || halfTick) begin
        halfCnt_ff <= '0;
      end else if (refTick) begin
        halfCnt_ff <= 11'(halfCnt_ff + 11'h001);
      end
    end
  end

  // ****************************************
  // data input synchroniser
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      misoSync_ff <= '0;
      misoFilt_ff <= 1'b0;
    end else if (ce) begin
      misoSync_ff <= {misoSync_ff[1:0], miso};
      if (misoSync_ff[1] == misoSync_ff[2]) begin
        misoFilt_ff <= misoSync_ff[2];
      end
    end
  end

  // ****************************************
  // shift engine
  // ****************************************
  assign leading = ~edgeCnt_ff[0];
  assign sampleEdge = leading ^ ctrl_ff.cpha;
  assign lastEdge = (edgeCnt_ff == 5'h1F);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= smd_pkg::ST_IDLE;
      frame_ff <= '0;
      edgeCnt_ff <= '0;
    end else if (ce) begin
      unique case (state_ff)
        smd_pkg::ST_IDLE: begin
          if (fifoOutValid) begin
            frame_ff <= fifoOut;
            edgeCnt_ff <= '0;
            state_ff <= smd_pkg::ST_LOAD;
          end
        end
        smd_pkg::ST_LOAD: begin
          if (halfTick) begin
            state_ff <= smd_pkg::ST_SHIFT;
          end
        end
        smd_pkg::ST_SHIFT: begin
          if (halfTick) begin
            edgeCnt_ff <= 5'(edgeCnt_ff + 5'h01);
            if (lastEdge) begin
              state_ff <= smd_pkg::ST_END;
            end
          end
        end
        smd_pkg::ST_END: begin
          if (halfTick) begin
            state_ff <= smd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chipSel_ff <= 2'b11;
    end else if (ce) begin
      chipSel_ff <= csLevels(ctrl_ff, state_ff != smd_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclk_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == smd_pkg::ST_SHIFT && halfTick) begin
        sclk_ff <= ~sclk_ff;
      end else if (state_ff == smd_pkg::ST_IDLE) begin
        sclk_ff <= ctrl_ff.cpol;
      end
    end
  end

  // read frames send the data word as written while the memory answers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mosi_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == smd_pkg::ST_LOAD && !ctrl_ff.cpha) begin
        mosi_ff <= frameBit(frame_ff, 4'h0, ctrl_ff.lsbFirst);
      end else if (state_ff == smd_pkg::ST_SHIFT && halfTick && !sampleEdge) begin
        if (ctrl_ff.cpha) begin
          mosi_ff <= frameBit(frame_ff, edgeCnt_ff[4:1], ctrl_ff.lsbFirst);
        end else if (!lastEdge) begin
          mosi_ff <= frameBit(frame_ff, 4'(edgeCnt_ff[4:1] + 4'h1),
                              ctrl_ff.lsbFirst);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxShift_ff <= '0;
    end else if (ce) begin
      if (state_ff == smd_pkg::ST_SHIFT && halfTick && sampleEdge && edgeCnt_ff[4]) begin
        if (ctrl_ff.lsbFirst) begin
          rxShift_ff <= {misoFilt_ff, rxShift_ff[7:1]};
        end else begin
          rxShift_ff <= {rxShift_ff[6:0], misoFilt_ff};
        end
      end
    end
  end

  // a capture in the same cycle as a software read keeps the flag set
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxData_ff <= '0;
      rxValid_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == smd_pkg::ST_END && halfTick && frame_ff.isRead) begin
        rxData_ff <= rxShift_ff;
        rxValid_ff <= 1'b1;
      end else if (rxRead) begin
        rxValid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sclk = sclk_ff;
  assign mosi = mosi_ff;
  assign chipSel = chipSel_ff;

endmodule : smd_spi_master

`default_nettype wire

// ### tb/smd_spi_master_sva.sv
// Purpose: port-level checks of the serial clock divider master
// Assumes: ctrl is shadowed from apb writes, one cycle late like the pins
// Notes: bound to the design after the module
`default_nettype none

module smd_spi_master_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic [1:0] chipSel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // helper logic
  // ************
  logic [5:0] ctlQ_ff;
  logic [5:0] ctl_ff;
  logic sclkQ_ff;
  logic [5:0] togCnt_ff;
  logic active;
  logic unmapped;
  assign active = (chipSel != ~ctl_ff[5:4]);
  assign unmapped = !(paddr inside {smd_pkg::CTRL_OFS, smd_pkg::TIMING_OFS, smd_pkg::FRAME_OFS,
                                    smd_pkg::STATUS_OFS, smd_pkg::RXDATA_OFS});
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctlQ_ff <= 6'h00;
      ctl_ff <= 6'h00;
    end else if (ce) begin
      if (psel && penable && pready && pwrite && paddr == smd_pkg::CTRL_OFS) begin
        ctlQ_ff <= pwdata[5:0];
      end
      ctl_ff <= ctlQ_ff;
    end
  end
  // toggles counted per frame, cleared while no line is selected
  always_ff @(posedge clk) begin
    sclkQ_ff <= sclk;
    if (!rst_b || !active) begin
      togCnt_ff <= 6'h00;
    end else if (sclk != sclkQ_ff) begin
      togCnt_ff <= togCnt_ff + 6'h01;
    end
  end
  // ************
  // assertions
  // ************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_wait_state: assert property (psel && penable && !$past(penable) |-> !pready)
    else $error("no wait state");
  a_unmapped_err: assert property (pready |-> pslverr == unmapped)
    else $error("pslverr does not match address");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_cs_selected: assert property (
    active |-> chipSel == (ctl_ff[3] ? {ctl_ff[5], ~ctl_ff[4]} : {~ctl_ff[5], ctl_ff[4]}))
    else $error("wrong chip select level");
  a_sclk_idle: assert property (!active |-> sclk == ctl_ff[0])
    else $error("sclk off idle level");
  a_mosi_edges: assert property (active && $past(active) && $changed(mosi) |-> $changed(sclk))
    else $error("mosi moved off a clock edge");
  a_frame_toggles: assert property ($fell(active) |-> togCnt_ff == 6'h20)
    else $error("frame toggle count wrong");
  a_cs_gap: assert property (
    $fell(active) |=> !active || (sclk == ctl_ff[0] && $stable(sclk)))
    else $error("next frame started off the idle clock level");
endmodule : smd_spi_master_sva

bind smd_spi_master smd_spi_master_sva u_sva (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sclk(sclk), .mosi(mosi), .miso(miso), .chipSel(chipSel));

`default_nettype wire

// ### tb/smd_mem_model.sv
// Purpose: behavioural serial memory on the far side of the master
// Assumes: address word is {read flag, 7-bit address}
// Notes: miso is not pulled, so it flips on a change of select and on each selected non-sampling edge outside read data
`default_nettype none

module smd_mem_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [1:0] chipSel,
  input wire smd_pkg::smd_ctrl_type cfg,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  logic [7:0] shIn;
  logic [7:0] addrW;
  logic [7:0] outB;
  logic sel;
  logic selQ = 1'b0;
  int bitCnt = 0;
  assign sel = (chipSel[cfg.csSel] === cfg.csPol[cfg.csSel]);
  initial miso = 1'b0;
  // one process owns miso: a change of select restarts the count and flips the line
  always @(sel or sclk) begin
    if (sel !== selQ) begin
      selQ = sel;
      bitCnt = 0;
      miso = ~miso;
    end else if (sel) begin
      if ((sclk != cfg.cpol) ^ cfg.cpha) begin
        shIn = cfg.lsbFirst ? {mosi, shIn[7:1]} : {shIn[6:0], mosi};
        bitCnt++;
        if (bitCnt == 8) begin
          addrW = shIn;
          outB = mem[shIn[6:0]];
        end
        if (bitCnt == 16 && !addrW[7]) mem[addrW[6:0]] = shIn;
      end else if (bitCnt >= 8 && bitCnt < 16 && addrW[7]) begin
        miso = cfg.lsbFirst ? outB[bitCnt - 8] : outB[15 - bitCnt];
      end else begin
        miso = ~miso;
      end
    end
  end
endmodule : smd_mem_model

`default_nettype wire

// ### tb/tb_spi_master_clock_divider.sv
// Purpose: self-checking bench of the serial clock divider master
// Assumes: 50 MHz clk, memory model on the far side
// Notes: rate is measured as clk cycles from first to last sclk toggle
`default_nettype none

module tb_spi_master_clock_divider;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    smd_pkg::smd_timing_type tim;
    smd_pkg::smd_ctrl_type ctl;
    logic [7:0] addr;
    logic [7:0] data;
    logic [11:0] per;
  } smd_row_type;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, sclk, mosi, miso, sclkQ, seen, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] chipSel;
  smd_pkg::smd_ctrl_type curCtl;
  smd_row_type rows [7];
  smd_row_type r;
  int fails, checked, cyc, t0, t1, h;

  smd_spi_master uut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .mosi(mosi), .miso(miso), .chipSel(chipSel));
  smd_mem_model model (.sclk(sclk), .mosi(mosi), .chipSel(chipSel), .cfg(curCtl), .miso(miso));

  always #10 clk = ~clk;
  // ************
  // span monitor and timeout
  // ************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sclkQ <= sclk;
    if (chipSel[curCtl.csSel] === curCtl.csPol[curCtl.csSel] && sclk !== sclkQ) begin
      if (!seen) t0 <= cyc;
      seen <= 1'b1;
      t1 <= cyc;
    end
    if (cyc == 90000) begin
      fails++;
      test_done();
    end
  end

  task automatic chkVal(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chkVal
  // fractional reference tick jitters one clk at each end
  task automatic chkNear(input string nm, input int exp, input int got);
    checked++;
    if (got < exp - 3 || got > exp + 3) begin
      fails++;
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chkNear
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic waitIdle;
    do apb(1'b0, smd_pkg::STATUS_OFS, 32'h0000_0000); while (rdat[0] !== 1'b0 || rdat[2] !== 1'b1);
  endtask : waitIdle
  task automatic frame(input logic rd, input logic [7:0] a, input logic [7:0] d);
    seen = 1'b0;
    apb(1'b1, smd_pkg::FRAME_OFS, {15'h0000, rd, rd, a[6:0], d});
    waitIdle();
  endtask : frame
  task automatic doReset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    curCtl = 6'h00;
  endtask : doReset
  task automatic test_done;
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ************
  // main sequence
  // ************
  initial begin
    {psel, penable, pwrite, sclkQ, seen} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {fails, checked, cyc} = '0;
    curCtl = 6'h00;
    // divisors kept within 1 to 255; last field is the serial period in reference cycles
    rows = '{{11'h004, 6'h00, 8'h11, 8'hA5, 12'h008},
             {11'h104, 6'h2D, 8'h22, 8'h3C, 12'h010},
             {11'h203, 6'h12, 8'h33, 8'h81, 12'h01A}, {11'h302, 6'h3F, 8'h44, 8'h6E, 12'h022},
             {11'h603, 6'h0A, 8'h55, 8'hC3, 12'h018}, {11'h702, 6'h05, 8'h66, 8'h18, 12'h020},
             {11'h4FF, 6'h00, 8'h7F, 8'hFF, 12'h1FE}};
    doReset();
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, smd_pkg::TIMING_OFS, {19'h0_0000, r.tim.divMode, 2'h0, r.tim.prescaleExponent,
                                       r.tim.divisorCount});
      apb(1'b1, smd_pkg::CTRL_OFS, {26'h000_0000, r.ctl});
      curCtl = r.ctl;
      frame(1'b0, r.addr, r.data);
      chkNear("span", 31 * int'(r.per) * 50 / 64, t1 - t0);
      chkVal("memory", {24'h00_0000, r.data}, {24'h00_0000, model.mem[r.addr[6:0]]});
      frame(1'b1, r.addr, 8'h00);
      chkVal("rxvalid", 32'h0000_0001, {31'h0000_0000, rdat[1]});
      apb(1'b0, smd_pkg::RXDATA_OFS, 32'h0000_0000);
      chkVal("rxdata", {24'h00_0000, r.data}, rdat);
    end
    doReset();
    apb(1'b0, smd_pkg::CTRL_OFS, 32'h0000_0000);
    chkVal("ctrl", 32'h0000_0000, rdat);
    apb(1'b0, smd_pkg::TIMING_OFS, 32'h0000_0000);
    chkVal("timing", 32'h0000_0001, rdat);
    chkVal("chipsel", 32'h0000_0003, {30'h0000_0000, chipSel});
    frame(1'b0, 8'h05, 8'h5A);
    chkNear("span", 31 * 50 / 32, t1 - t0);
    apb(1'b1, 8'h14, 32'h0000_00FF);
    chkVal("slverr", 32'h0000_0001, {31'h0000_0000, rerr});
    apb(1'b0, 8'h14, 32'h0000_0000);
    chkVal("unmapped", 32'h0000_0000, rdat);
    // slow enough that 17 pushes outrun the first frame
    apb(1'b1, smd_pkg::TIMING_OFS, 32'h0000_0002);
    for (int i = 0; i < 17; i++) apb(1'b1, smd_pkg::FRAME_OFS, 32'(i));
    apb(1'b0, smd_pkg::STATUS_OFS, 32'h0000_0000);
    chkVal("status", 32'h0000_1009, rdat);
    h = cyc;
    apb(1'b1, smd_pkg::FRAME_OFS, 32'h0000_0011);
    chkVal("stall", 32'h0000_0001, {31'h0000_0000, (cyc - h) > 10});
    // clock enable low in mid-frame: chip selects and sclk must hold still
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    rdat = {29'h0000_0000, chipSel, sclk};
    repeat (30) begin
      @(posedge clk);
      chkVal("frozen", rdat, {29'h0000_0000, chipSel, sclk});
    end
    ce <= 1'b1;
    waitIdle();
    test_done();
  end
endmodule : tb_spi_master_clock_divider

`default_nettype wire
